// file: hw/tpp_positioner.sv
// Trapezoidal profile pulse positioner with register port and interrupt.

module tpp_positioner #(
    parameter int CTRL_CYC = tpp_pkg::CTRL_PERIOD_CYC,
    parameter int MAX_FREQ = tpp_pkg::MAX_FREQ_HZ
) (
    input  wire logic            ref_clk,
    input  wire logic            reset,
    input  wire tpp_pkg::tpp_bus_s bus,
    output logic [tpp_pkg::DW-1:0] rdata,
    input  wire tpp_pkg::tpp_ctx_s ctx,
    input  wire logic            hasTransistorOut,
    output logic [1:0]           pulseOutA,
    output logic [1:0]           pulseOutB,
    output logic                 inProgress,
    output logic                 instructionErrorFlag,
    output logic                 irq
);
    import tpp_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CTRL_CYC < 2) begin : g_bad_period
        $error("control period too short");
    end
    if (CTRL_CYC > CLK_HZ) begin : g_bad_long
        $error("control period longer than one second");
    end
    if (MAX_FREQ < 1) begin : g_bad_fmin
        $error("maximum frequency must be positive");
    end
    if (2 * longint'(MAX_FREQ) >= longint'(CLK_HZ)) begin : g_bad_freq
        $error("maximum frequency too high for clock");
    end

    localparam logic [31:0] CTRL_LAST = 32'(CTRL_CYC - 1);
    localparam logic [31:0] MAX_F     = 32'(MAX_FREQ);
    // Control periods per second follow the period length in use.
    localparam logic [47:0] PPS       = 48'(CLK_HZ / CTRL_CYC);

    function automatic logic [47:0] pulsesToHz(input logic [32:0] n);
        pulsesToHz = {15'h0000, n} * PPS;
    endfunction

    function automatic logic running(input tpp_phase_e p);
        running = (p == TPP_ACCEL) || (p == TPP_CONST) || (p == TPP_DECEL);
    endfunction

    // Lowers a frequency by one step but never below the floor value.
    function automatic logic [31:0] stepDown(input logic [31:0] f,
                                             input logic [31:0] lowest,
                                             input logic [15:0] dec);
        stepDown = (f - lowest > {16'h0000, dec}) ? f - {16'h0000, dec}
                                                  : lowest;
    endfunction

    tpp_state_s s_r;
    tpp_state_s s_nxt;

    logic              ncoWave;
    logic              ncoRise;
    logic              ncoClear;
    logic              portSel;
    logic              portOk;
    logic              modeAbs;
    logic signed [32:0] absDiff;
    logic [32:0]       absMag;
    logic [32:0]       moveMag;
    logic              moveNeg;
    logic              errRange;
    logic              errBusy;
    logic              errCtx;
    logic              errOrigin;
    logic              cmdErr;
    logic              execWr;
    logic              execTaken;
    logic              stopWr;
    logic              originWr;
    logic              tick;
    logic [DW-1:0]     rdNext;

    // ------------------------------------------------------------------
    // Command decode and checks
    // ------------------------------------------------------------------
    assign portSel = s_r.portCode[0];
    assign portOk  = (s_r.portCode == PORT_OUT0)
                  || (s_r.portCode == PORT_OUT1);
    assign modeAbs = s_r.mode[MODE_ABS_BIT];
    assign absDiff = $signed({s_r.count[31], s_r.count})
                   - $signed({s_r.pos[portSel][31], s_r.pos[portSel]});
    assign absMag  = absDiff[32] ? 33'(-absDiff) : 33'(absDiff);
    assign moveMag = modeAbs ? absMag : {1'b0, s_r.count};
    assign moveNeg = modeAbs ? absDiff[32] : s_r.mode[MODE_DIR_BIT];

    assign errRange = !portOk
                   || ((s_r.mode & ~MODE_USED_MASK) != RESET_WORD16)
                   || (s_r.accel == RESET_WORD16)
                   || (s_r.decel == RESET_WORD16)
                   || (s_r.startFreq == RESET_WORD32)
                   || (s_r.startFreq > MAX_F)
                   || (s_r.target > MAX_F)
                   || (s_r.target < s_r.startFreq)
                   || (!modeAbs && s_r.count[31]);
    assign errBusy   = ctx.fixedSpeedBusy[portSel]
                    || ctx.originSearchBusy[portSel];
    assign errCtx    = ctx.fromIrqContext && ctx.cyclicPulseBusy;
    assign errOrigin = modeAbs && !s_r.originEst[portSel];
    assign cmdErr    = errRange || errBusy || errCtx || errOrigin;

    assign execWr   = bus.wr && (bus.addr == REG_CTRL)
                   && bus.wdata[CTRL_EXEC_BIT];
    assign stopWr   = bus.wr && (bus.addr == REG_CTRL)
                   && bus.wdata[CTRL_STOP_BIT];
    assign originWr = bus.wr && (bus.addr == REG_CTRL)
                   && bus.wdata[CTRL_ORIGIN_BIT];
    assign tick     = running(s_r.phase) && (s_r.periodCnt == CTRL_LAST);
    // A refused command must leave the phase of a running move alone.
    assign execTaken = execWr && s_r.strapSync[1]
                    && !((s_r.phase == TPP_HOLD) && s_r.ctlStop);
    assign ncoClear  = execTaken && !cmdErr;

    // ------------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------------
    tpp_pulse_nco #(
        .CLK_RATE (CLK_HZ)
    ) u_nco (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clear   (ncoClear),
        .run     (running(s_r.phase)),
        .freqHz  (s_r.freq),
        .wave    (ncoWave),
        .rise    (ncoRise)
    );

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        case (bus.addr)
            REG_PORT:   rdNext = {16'h0000, s_r.portCode};
            REG_MODE:   rdNext = {16'h0000, s_r.mode};
            REG_COUNT:  rdNext = s_r.count;
            REG_TARGET: rdNext = s_r.target;
            REG_ACCEL:  rdNext = {16'h0000, s_r.accel};
            REG_DECEL:  rdNext = {16'h0000, s_r.decel};
            REG_START:  rdNext = s_r.startFreq;
            REG_STATUS: rdNext = {24'h000000, s_r.phase, s_r.originEst,
                                  s_r.errFlag, s_r.phase != TPP_IDLE,
                                  running(s_r.phase)};
            REG_POS0:   rdNext = s_r.pos[0];
            REG_POS1:   rdNext = s_r.pos[1];
            REG_FREQ:   rdNext = s_r.freq;
            REG_IRQ_ST: rdNext = {30'h0000_0000, s_r.irqSt};
            REG_IRQ_EN: rdNext = {30'h0000_0000, s_r.irqEn};
            default:    rdNext = RESET_WORD32;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // The strap passes two flip-flops before any command reads it.
        s_nxt.strapSync = {s_r.strapSync[0], hasTransistorOut};
        s_nxt.rdata = bus.rd ? rdNext : RESET_WORD32;

        // Register writes; the start frequency arrives as one
        // 32-bit word whose low half is the low word.
        if (bus.wr) begin
            case (bus.addr)
                REG_PORT:   s_nxt.portCode  = bus.wdata[15:0];
                REG_MODE:   s_nxt.mode      = bus.wdata[15:0];
                REG_COUNT:  s_nxt.count     = bus.wdata;
                REG_TARGET: s_nxt.target    = bus.wdata;
                REG_ACCEL:  s_nxt.accel     = bus.wdata[15:0];
                REG_DECEL:  s_nxt.decel     = bus.wdata[15:0];
                REG_START:  s_nxt.startFreq = bus.wdata;
                REG_IRQ_EN: s_nxt.irqEn     = bus.wdata[IRQ_W-1:0];
                default:    s_nxt.irqEn     = s_r.irqEn;
            endcase
        end
        if (bus.wr && (bus.addr == REG_IRQ_CLR)) begin
            s_nxt.irqSt = s_r.irqSt & ~bus.wdata[IRQ_W-1:0];
        end

        // Control period timer runs only while pulses are emitted.
        if (running(s_r.phase)) begin
            s_nxt.periodCnt = tick ? RESET_WORD32 : s_r.periodCnt + 32'd1;
        end

        // Iterative estimate of the hertz-periods needed to come down.
        if (s_r.calcBusy) begin
            if (s_r.calcF > s_r.startFreq) begin
                s_nxt.calcSum = s_r.calcSum + {16'h0000, s_r.calcF};
                s_nxt.calcF = stepDown(s_r.calcF, s_r.startFreq, s_r.decel);
            end else begin
                s_nxt.calcBusy = 1'b0;
                if (((s_r.phase == TPP_ACCEL) || (s_r.phase == TPP_CONST))
                    && (s_r.calcSum >= pulsesToHz(s_r.remaining))) begin
                    s_nxt.phase = TPP_DECEL;
                end
            end
        end

        case (s_r.phase)
            TPP_ACCEL: begin
                if (tick) begin
                    if ({1'b0, s_r.freq} + {17'h00000, s_r.accel}
                        >= {1'b0, s_r.target}) begin
                        s_nxt.freq  = s_r.target;
                        s_nxt.phase = TPP_CONST;
                    end else begin
                        s_nxt.freq = s_r.freq + {16'h0000, s_r.accel};
                    end
                end
            end
            TPP_CONST: begin
                s_nxt.freq = s_r.freq;
            end
            TPP_DECEL: begin
                if (tick) begin
                    s_nxt.freq = stepDown(s_r.freq, s_r.startFreq,
                                          s_r.decel);
                end
            end
            TPP_HOLD: begin
                s_nxt.phase   = TPP_IDLE;
                s_nxt.ctlStop = 1'b0;
            end
            default: begin
                s_nxt.phase = TPP_IDLE;
            end
        endcase

        // Each control period that ends with no estimate running re-estimates the deceleration point.
        if (tick && !s_r.calcBusy) begin
            s_nxt.calcBusy = 1'b1;
            s_nxt.calcF    = s_nxt.freq;
            s_nxt.calcSum  = 48'h0000_0000_0000;
        end

        // Pulse accounting; the move ends on the last commanded pulse.
        if (ncoRise && running(s_r.phase)) begin
            s_nxt.pos[s_r.actPort] = s_r.actNeg
                ? s_r.pos[s_r.actPort] - 32'd1
                : s_r.pos[s_r.actPort] + 32'd1;
            s_nxt.remaining = s_r.remaining - 33'd1;
            if (s_r.remaining == 33'd1) begin
                s_nxt.phase    = TPP_HOLD;
                s_nxt.calcBusy = 1'b0;
                s_nxt.irqSt[IRQ_DONE_BIT] = 1'b1;
            end
        end

        if (stopWr && running(s_r.phase)) begin
            s_nxt.phase     = TPP_HOLD;
            s_nxt.ctlStop   = 1'b1;
            s_nxt.remaining = 33'd0;
            s_nxt.calcBusy  = 1'b0;
            s_nxt.irqSt[IRQ_DONE_BIT] = 1'b1;
        end

        if (originWr && !(running(s_r.phase) && s_r.actPort == portSel)) begin
            s_nxt.originEst[portSel] = 1'b1;
            s_nxt.pos[portSel]       = RESET_WORD32;
        end

        // An error-free command restarts the sequence, even in the trailing cycle,
        // unless a control stop just happened or the outputs are absent.
        if (execTaken) begin
            s_nxt.errFlag = cmdErr;
            if (cmdErr) begin
                s_nxt.irqSt[IRQ_ERR_BIT] = 1'b1;
            end else begin
                s_nxt.actPort   = portSel;
                s_nxt.actNeg    = moveNeg;
                s_nxt.actForm   = s_r.mode[MODE_FORM_BIT];
                s_nxt.freq      = s_r.startFreq;
                s_nxt.remaining = moveMag;
                s_nxt.periodCnt = RESET_WORD32;
                s_nxt.ctlStop   = 1'b0;
                s_nxt.calcBusy  = 1'b1;
                s_nxt.calcF     = s_r.startFreq;
                s_nxt.calcSum   = 48'h0000_0000_0000;
                s_nxt.phase     = (moveMag == 33'd0) ? TPP_HOLD
                                                     : TPP_ACCEL;
            end
        end

        // Output drive: pulse plus direction, or separate CW and CCW.
        // Lines drop in the hold cycle, so the last pulse is one clock wide.
        s_nxt.outA = 2'b00;
        s_nxt.outB = 2'b00;
        if (running(s_r.phase)) begin
            if (s_r.actForm) begin
                s_nxt.outA[s_r.actPort] = ncoWave;
                s_nxt.outB[s_r.actPort] = s_r.actNeg;
            end else begin
                s_nxt.outA[s_r.actPort] = ncoWave && !s_r.actNeg;
                s_nxt.outB[s_r.actPort] = ncoWave && s_r.actNeg;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata                = s_r.rdata;
    assign pulseOutA            = s_r.outA;
    assign pulseOutB            = s_r.outB;
    assign inProgress           = s_r.phase != TPP_IDLE;
    assign instructionErrorFlag = s_r.errFlag;
    assign irq                  = |(s_r.irqSt & s_r.irqEn);
endmodule

// file: hw/tpp_pkg.sv
// Package of constants, register map and carrier types for the positioner.
package tpp_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int CTRL_PERIOD_NS  = 4_000_000;
    localparam int CTRL_PERIOD_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PERIODS_PER_SEC = 1_000_000_000 / CTRL_PERIOD_NS;
    localparam int MAX_FREQ_HZ     = 100_000;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [AW-1:0] REG_CTRL    = 8'h00;
    localparam logic [AW-1:0] REG_PORT    = 8'h04;
    localparam logic [AW-1:0] REG_MODE    = 8'h08;
    localparam logic [AW-1:0] REG_COUNT   = 8'h0c;
    localparam logic [AW-1:0] REG_TARGET  = 8'h10;
    localparam logic [AW-1:0] REG_ACCEL   = 8'h14;
    localparam logic [AW-1:0] REG_DECEL   = 8'h18;
    localparam logic [AW-1:0] REG_START   = 8'h1c;
    localparam logic [AW-1:0] REG_STATUS  = 8'h20;
    localparam logic [AW-1:0] REG_POS0    = 8'h24;
    localparam logic [AW-1:0] REG_POS1    = 8'h28;
    localparam logic [AW-1:0] REG_FREQ    = 8'h2c;
    localparam logic [AW-1:0] REG_IRQ_ST  = 8'h30;
    localparam logic [AW-1:0] REG_IRQ_CLR = 8'h34;
    localparam logic [AW-1:0] REG_IRQ_EN  = 8'h38;

    localparam int CTRL_EXEC_BIT   = 0;
    localparam int CTRL_STOP_BIT   = 1;
    localparam int CTRL_ORIGIN_BIT = 2;

    localparam logic [15:0] PORT_OUT0 = 16'h0000;
    localparam logic [15:0] PORT_OUT1 = 16'h0001;

    localparam int          MODE_DIR_BIT   = 0;
    localparam int          MODE_FORM_BIT  = 1;
    localparam int          MODE_ABS_BIT   = 2;
    localparam logic [15:0] MODE_USED_MASK = 16'h0007;

    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT  = 1;
    localparam int IRQ_W        = 2;

    localparam logic [15:0] RESET_WORD16 = 16'h0000;
    localparam logic [31:0] RESET_WORD32 = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TPP_IDLE, TPP_ACCEL, TPP_CONST, TPP_DECEL, TPP_HOLD
    } tpp_phase_e;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } tpp_bus_s;

    typedef struct packed {
        logic [1:0] fixedSpeedBusy;
        logic [1:0] originSearchBusy;
        logic       fromIrqContext;
        logic       cyclicPulseBusy;
    } tpp_ctx_s;

    typedef struct packed {
        logic [31:0] acc;
        logic        wave;
        logic        rise;
    } tpp_nco_s;

    typedef struct packed {
        tpp_phase_e       phase;
        logic [15:0]      portCode;
        logic [15:0]      mode;
        logic [31:0]      count;
        logic [31:0]      target;
        logic [15:0]      accel;
        logic [15:0]      decel;
        logic [31:0]      startFreq;
        logic [31:0]      freq;
        logic [32:0]      remaining;
        logic             actPort;
        logic             actNeg;
        logic             actForm;
        logic             ctlStop;
        logic             errFlag;
        logic [1:0]       originEst;
        logic [1:0][31:0] pos;
        logic [31:0]      periodCnt;
        logic             calcBusy;
        logic [31:0]      calcF;
        logic [47:0]      calcSum;
        logic [1:0]       outA;
        logic [1:0]       outB;
        logic [IRQ_W-1:0] irqSt;
        logic [IRQ_W-1:0] irqEn;
        logic [DW-1:0]    rdata;
        logic [1:0]       strapSync;
    } tpp_state_s;

endpackage

// file: hw/tpp_pulse_nco.sv
// Phase accumulator that turns a frequency in hertz into a square wave.
module tpp_pulse_nco #(
    parameter int CLK_RATE = tpp_pkg::CLK_HZ
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        clear,
    input  wire logic        run,
    input  wire logic [31:0] freqHz,
    output logic             wave,
    output logic             rise
);
    import tpp_pkg::*;

    localparam logic [31:0] CLK_RATE_W = 32'(CLK_RATE);

    tpp_nco_s s_r;
    tpp_nco_s s_nxt;
    logic [32:0] sum;

    // The wave toggles at twice the pulse rate, one full pulse per period.
    assign sum = {1'b0, s_r.acc} + {freqHz, 1'b0};

    always_comb begin
        s_nxt = s_r;
        s_nxt.rise = 1'b0;
        if (clear || !run) begin
            s_nxt.acc  = RESET_WORD32;
            s_nxt.wave = 1'b0;
        end else if (sum >= {1'b0, CLK_RATE_W}) begin
            s_nxt.acc  = 32'(sum - {1'b0, CLK_RATE_W});
            s_nxt.wave = !s_r.wave;
            s_nxt.rise = !s_r.wave;
        end else begin
            s_nxt.acc = sum[31:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wave = s_r.wave;
    assign rise = s_r.rise;
endmodule

// file: dv/tpp_motor_model.sv
// Motor drive model that counts step edges on both lines of each port.
module tpp_motor_model (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [1:0]       stepA,
    input  wire logic [1:0]       stepB,
    output logic      [1:0][15:0] cntA,
    output logic      [1:0][15:0] cntB
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] lastA;
    logic [1:0] lastB;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lastA <= 2'h0;
            lastB <= 2'h0;
            cntA  <= '0;
            cntB  <= '0;
        end else begin
            lastA <= stepA;
            lastB <= stepB;
            for (int p = 0; p < 2; p++) begin
                if (stepA[p] && !lastA[p]) begin
                    cntA[p] <= cntA[p] + 16'h1;
                end
                if (stepB[p] && !lastB[p]) begin
                    cntB[p] <= cntB[p] + 16'h1;
                end
            end
        end
    end
endmodule

// file: dv/tpp_positioner_chk.sv
// Concurrent checks bound to the pulse positioner's ports.
module tpp_positioner_chk
    import tpp_pkg::*;
#(
    parameter int CTRL_CYC = CTRL_PERIOD_CYC,
    parameter int MAX_FREQ = MAX_FREQ_HZ
) (
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire tpp_pkg::tpp_bus_s    bus,
    input wire logic [tpp_pkg::DW-1:0] rdata,
    input wire tpp_pkg::tpp_ctx_s    ctx,
    input wire logic                 hasTransistorOut,
    input wire logic [1:0]           pulseOutA,
    input wire logic [1:0]           pulseOutB,
    input wire logic                 inProgress,
    input wire logic                 instructionErrorFlag,
    input wire logic                 irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] strapHist_r;
    logic       execWr;
    logic       strapOk;

    assign execWr = bus.wr && (bus.addr == REG_CTRL)
                 && bus.wdata[CTRL_EXEC_BIT];
    assign strapOk = (strapHist_r == 4'hf) && hasTransistorOut;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            strapHist_r <= 4'h0;
        end else begin
            strapHist_r <= {strapHist_r[2:0], hasTransistorOut};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == '0)
        else $error("read data not zero outside read slot");
    a_err_cause: assert property (
        $changed(instructionErrorFlag) |-> $past(execWr))
        else $error("error flag moved without a command");
    a_busy_err: assert property (execWr && strapOk && !inProgress &&
        ctx.fixedSpeedBusy == 2'b11 |=> instructionErrorFlag)
        else $error("busy port accepted a command");
    a_ctx_err: assert property (execWr && strapOk && !inProgress &&
        ctx.fromIrqContext && ctx.cyclicPulseBusy |=> instructionErrorFlag)
        else $error("interrupt context clash not flagged");
    a_strap_nop: assert property (execWr && strapHist_r[1:0] == 2'b00 &&
        !hasTransistorOut |=> $stable(instructionErrorFlag) && !inProgress)
        else $error("command acted without pulse outputs");
    a_start_cause: assert property ($rose(inProgress) |-> $past(execWr))
        else $error("motion began without a command");
    a_idle_quiet: assert property ((!inProgress) [*3] |->
        (pulseOutA & ~$past(pulseOutA)) == 2'b00)
        else $error("pulse edge while idle");
    a_irq_cause: assert property ($rose(irq) |->
        $past(bus.wr) || $past(inProgress))
        else $error("interrupt rose without an event");
endmodule

bind tpp_positioner tpp_positioner_chk #(
    .CTRL_CYC(CTRL_CYC), .MAX_FREQ(MAX_FREQ)) uChk (
    .ref_clk(ref_clk), .reset(reset), .bus(bus), .rdata(rdata),
    .ctx(ctx), .hasTransistorOut(hasTransistorOut),
    .pulseOutA(pulseOutA), .pulseOutB(pulseOutB),
    .inProgress(inProgress),
    .instructionErrorFlag(instructionErrorFlag), .irq(irq));

// file: dv/test_tpp_positioner.sv
// Self-checking bench for the trapezoidal pulse positioner.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin badCount++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module test_tpp_positioner;
    timeunit 1ns;
    timeprecision 1ns;
    import tpp_pkg::*;

    localparam int CYC = 50;
    localparam logic [AW-1:0] B_ADDR [8] = '{REG_PORT, REG_MODE, REG_START,
        REG_ACCEL, REG_MODE, REG_PORT, REG_PORT, REG_PORT};
    localparam logic [DW-1:0] B_VAL [8] = '{32'h2, 32'ha, 32'h0, 32'h0,
        32'h6, 32'h0, 32'h0, 32'h0};
    localparam logic [DW-1:0] G_VAL [8] = '{32'h0, 32'h2, 32'h4e20,
        32'h4e20, 32'h2, 32'h0, 32'h0, 32'h0};
    localparam logic [5:0] B_CTX [8] = '{6'h0, 6'h0, 6'h0, 6'h0, 6'h0,
        6'h30, 6'h04, 6'h03};

    logic             ref_clk;
    logic             reset;
    tpp_bus_s         bus;
    logic [DW-1:0]    rdata;
    tpp_ctx_s         ctx;
    logic             strap;
    logic [1:0]       pulseOutA;
    logic [1:0]       pulseOutB;
    logic             inProgress;
    logic             errFlag;
    logic             irq;
    logic [1:0][15:0] cntA;
    logic [1:0][15:0] cntB;
    logic [15:0]      base;
    int               badCount;
    int               checked;

    tpp_positioner #(.CTRL_CYC(CYC)) uut (
        .ref_clk(ref_clk), .reset(reset), .bus(bus), .rdata(rdata),
        .ctx(ctx), .hasTransistorOut(strap), .pulseOutA(pulseOutA),
        .pulseOutB(pulseOutB), .inProgress(inProgress),
        .instructionErrorFlag(errFlag), .irq(irq));

    tpp_motor_model drive (
        .ref_clk(ref_clk), .reset(reset), .stepA(pulseOutA),
        .stepB(pulseOutB), .cntA(cntA), .cntB(cntB));

    // ------------------------------------------------------------------
    // Bus, wait and summary tasks
    // ------------------------------------------------------------------
    task automatic put(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        put(a, d);
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    task automatic cmd(input logic e);
        wreg(REG_CTRL, 32'h1);
        `CHK(errFlag, e)
    endtask

    task automatic waitIdle;
        for (int n = 0; n < 20000 && inProgress !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(inProgress, 1'b0)
    endtask

    task automatic summarize;
        $display("checked %0d badCount %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        #(60000 * 50);
        badCount++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        bus = '0;
        ctx = '0;
        strap = 1'b1;
        badCount = 0;
        checked = 0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        rchk(REG_STATUS, 32'h0);
        rchk(REG_IRQ_CLR, 32'h0);
        rchk(8'h3c, 32'h0);
        wreg(REG_MODE, 32'h2);
        wreg(REG_TARGET, 32'd100000);
        wreg(REG_START, 32'd20000);
        wreg(REG_DECEL, 32'd20000);
        wreg(REG_IRQ_EN, 32'h3);
        cmd(1'b1);
        `CHK(irq, 1'b1)
        wreg(REG_ACCEL, 32'd20000);
        cmd(1'b0);
        for (int i = 0; i < 8; i++) begin
            wreg(B_ADDR[i], B_VAL[i]);
            @(posedge ref_clk);
            ctx <= B_CTX[i];
            cmd(1'b1);
            @(posedge ref_clk);
            ctx <= '0;
            wreg(B_ADDR[i], G_VAL[i]);
            cmd(1'b0);
        end
        @(posedge ref_clk);
        strap <= 1'b0;
        wreg(REG_ACCEL, 32'h0);
        cmd(1'b0);
        `CHK(inProgress, 1'b0)
        wreg(REG_ACCEL, 32'd20000);
        @(posedge ref_clk);
        strap <= 1'b1;
        wreg(REG_IRQ_CLR, 32'h3);
        `CHK(irq, 1'b0)
        wreg(REG_IRQ_EN, 32'h2);
        wreg(REG_COUNT, 32'd12);
        cmd(1'b0);
        `CHK(inProgress, 1'b1)
        rchk(REG_FREQ, 32'd20000);
        waitIdle();
        `CHK(cntA[0], 16'd12)
        `CHK(cntA[1], 16'd0)
        rchk(REG_POS0, 32'd12);
        `CHK(irq, 1'b0)
        rchk(REG_IRQ_ST, 32'h1);
        wreg(REG_IRQ_EN, 32'h3);
        `CHK(irq, 1'b1)
        wreg(REG_COUNT, 32'd200000);
        cmd(1'b0);
        repeat (2 * CYC + CYC / 2) @(posedge ref_clk);
        rchk(REG_FREQ, 32'd60000);
        repeat (4 * CYC) @(posedge ref_clk);
        rchk(REG_FREQ, 32'd100000);
        cmd(1'b0);
        rchk(REG_FREQ, 32'd20000);
        put(REG_CTRL, 32'h2);
        put(REG_CTRL, 32'h1);
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK(inProgress, 1'b0)
        wreg(REG_CTRL, 32'h4);
        rchk(REG_POS0, 32'h0);
        wreg(REG_MODE, 32'h6);
        wreg(REG_COUNT, 32'hffff_fffb);
        base = cntA[0];
        cmd(1'b0);
        waitIdle();
        `CHK(cntA[0] - base, 16'd5)
        rchk(REG_POS0, 32'hffff_fffb);
        wreg(REG_PORT, 32'h1);
        wreg(REG_MODE, 32'h1);
        wreg(REG_COUNT, 32'd3);
        cmd(1'b0);
        waitIdle();
        `CHK(cntB[1], 16'd3)
        `CHK(cntA[1], 16'd0)
        summarize();
    end
endmodule
